// >>> bench/fdrs_drive_model.sv
`timescale 1ns/1ps
// ------------------------------
// Drive side of the density pins
// ------------------------------
module fdrs_drive_model (
  input wire clk,
  input wire density_pin_zero,
  input wire density_pin_one,
  input wire precomp_disable,
  output logic [2:0] drive_view
);
  // A drive latches its mode lines late, so the bench sees them one edge on
  always @(posedge clk) begin
    drive_view <= {density_pin_zero, density_pin_one, precomp_disable};
  end
endmodule

// >>> bench/fdrs_top_chk.sv
`timescale 1ns/1ps
module fdrs_top_chk (
  input wire clk,
  input wire rstn,
  input wire device_active,
  input wire base_addr_valid,
  input wire powered_down,
  input wire at_mode,
  input wire core_irq,
  input wire core_dack,
  input wire dreq_in,
  input wire [1:0] rate_sel,
  input wire irq_oe_n,
  input wire dack_oe_n,
  input wire irq_out,
  input wire dack_out,
  input wire dreq_to_core,
  input wire [7:0] shared_data_mask,
  input wire [2:0] selected_rate,
  input wire media_density_code,
  input wire dma_non_burst,
  input wire cfg_reset_active
);
  // ------------------------------
  // Port relations
  // ------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  wire off = !device_active || !base_addr_valid || powered_down;
  a_irq_float: assert property (off |-> irq_oe_n) else $error("irq driven while off");
  a_dack_float: assert property (off |-> dack_oe_n) else $error("dack driven");
  a_irq_pass: assert property (!irq_oe_n |-> irq_out == core_irq) else $error("irq copy");
  a_dack_pass: assert property (!dack_oe_n |-> dack_out == core_dack) else $error("dack copy");
  a_dreq_gate: assert property (dreq_to_core |-> dreq_in && !powered_down)
    else $error("dreq passed");
  a_mask_at: assert property (at_mode && shared_data_mask != 0 |-> shared_data_mask == 8'h80)
    else $error("at mask");
  a_mask_full: assert property (!at_mode && shared_data_mask != 0 |-> shared_data_mask == 8'hff)
    else $error("full mask");
  a_rate_1m: assert property (!cfg_reset_active && rate_sel == 2'h3 |=>
    cfg_reset_active || selected_rate == 3'h1) else $error("rate 1m");
  a_dens_map: assert property (!cfg_reset_active |=> cfg_reset_active ||
    media_density_code == ($past(rate_sel[1]) == $past(rate_sel[0]))) else $error("density");
  a_non_burst: assert property (!$past(rstn) |-> dma_non_burst) else $error("burst");
  a_host_clr: assert property (cfg_reset_active |=> selected_rate == 3'h0) else $error("clr");
  c_at_read: cover property (at_mode && shared_data_mask == 8'h80);
  c_host_rst: cover property (cfg_reset_active);
  c_tape_2m: cover property (selected_rate == 3'h5);
endmodule
bind fdrs_top fdrs_top_chk chk (
  .clk(clk), .rstn(rstn), .device_active(device_active), .base_addr_valid(base_addr_valid),
  .powered_down(powered_down), .at_mode(at_mode), .core_irq(core_irq), .core_dack(core_dack),
  .dreq_in(dreq_in), .rate_sel(rate_sel), .irq_oe_n(irq_oe_n), .dack_oe_n(dack_oe_n),
  .irq_out(irq_out), .dack_out(dack_out), .dreq_to_core(dreq_to_core),
  .shared_data_mask(shared_data_mask), .selected_rate(selected_rate),
  .media_density_code(media_density_code), .dma_non_burst(dma_non_burst),
  .cfg_reset_active(cfg_reset_active)
);

// >>> bench/test_floppy_drive_rate_density_select.sv
`timescale 1ns/1ps
module test_floppy_drive_rate_density_select;
  logic clk, rstn, host_reset_in, cfg_wr, cfg_rd, dor_wr, device_active, base_addr_valid;
  logic powered_down, at_mode, core_irq, core_dack, dreq_in, shared_rd;
  logic [7:0] cfg_index, cfg_wdata, dor_wdata, seen;
  logic [1:0] drive_sel, rate_sel;
  wire [7:0] cfg_rdata, shared_data_mask;
  wire irq_out, irq_oe_n, dack_out, dack_oe_n, dreq_to_core, density_pin_zero, density_pin_one;
  wire precomp_disable, media_density_code, dma_non_burst, cfg_reset_active;
  wire [2:0] selected_rate, drive_view;
  logic [9:0] q[$];
  string what;
  int n_errors = 0;
  int cmp_count = 0;
  fdrs_top dut (
    .clk(clk), .rstn(rstn), .host_reset_in(host_reset_in), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .dor_wr(dor_wr),
    .dor_wdata(dor_wdata), .drive_sel(drive_sel), .rate_sel(rate_sel),
    .device_active(device_active), .base_addr_valid(base_addr_valid),
    .powered_down(powered_down), .at_mode(at_mode), .core_irq(core_irq),
    .core_dack(core_dack), .dreq_in(dreq_in), .shared_rd(shared_rd), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n), .dack_out(dack_out), .dack_oe_n(dack_oe_n),
    .dreq_to_core(dreq_to_core), .shared_data_mask(shared_data_mask),
    .density_pin_zero(density_pin_zero), .density_pin_one(density_pin_one),
    .precomp_disable(precomp_disable), .selected_rate(selected_rate),
    .media_density_code(media_density_code), .dma_non_burst(dma_non_burst),
    .cfg_reset_active(cfg_reset_active)
  );
  fdrs_drive_model drv (
    .clk(clk), .density_pin_zero(density_pin_zero), .density_pin_one(density_pin_one),
    .precomp_disable(precomp_disable), .drive_view(drive_view)
  );
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // ------------------------------
  // Watcher: oldest note against what is seen
  // ------------------------------
  always @(negedge clk) begin
    while (q.size() > 0) begin
      case (q[0][9:8])
        2'h0: begin
          seen = cfg_rdata;
          what = "cfg_rdata";
        end
        2'h1: begin
          seen = {drive_view, media_density_code, 1'b0, selected_rate};
          what = "drive_pins";
        end
        2'h2: begin
          seen = {irq_oe_n, dack_oe_n, irq_out, dack_out, dreq_to_core, 3'h0};
          what = "irq_dack_gate";
        end
        default: begin
          seen = shared_data_mask;
          what = "shared_data_mask";
        end
      endcase
      cmp_count++;
      if (seen !== q[0][7:0]) begin
        n_errors++;
        $display("MISMATCH %s exp %h seen %h", what, q[0][7:0], seen);
      end
      void'(q.pop_front());
    end
  end
  task automatic note(logic [1:0] k, logic [7:0] v);
    q.push_back({k, v});
    @(negedge clk);
  endtask
  task automatic cfg_access(logic w, logic [7:0] i, logic [7:0] d);
    @(posedge clk);
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_index <= i;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 0;
    cfg_rd <= 0;
    if (!w) note(0, d);
  endtask
  function automatic logic [7:0] pins(logic [7:0] d, logic [1:0] r);
    logic dn;
    logic [1:0] p;
    logic [2:0] c;
    dn = r[1] == r[0];
    case (d[1:0])
      0: p = {dn, r[0]};
      1: p = {r[1], r[0]};
      2: p = {!dn, r[0]};
      default: p = {r[0], r[1]};
    endcase
    c = r == 3 ? 3'h1 : r == 0 ? 3'h2 : r == 2 ? 3'h4 : d[4:3] == 0 ? 3'h3 : d[4] ? 3'h5 : 3'h2;
    return {p, d[6], dn, 1'b0, c};
  endfunction
  task automatic results;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    results;
  end
  initial begin
    logic [7:0] d;
    logic [1:0] k;
    logic en;
    {cfg_wr, cfg_rd, dor_wr, host_reset_in, shared_rd, core_irq, core_dack, dreq_in} = 0;
    {device_active, base_addr_valid, powered_down, at_mode, rstn} = 5'b11000;
    {cfg_index, cfg_wdata, dor_wdata, drive_sel, rate_sel} = 0;
    d = $urandom(32'h7447ebce);
    repeat (8) @(posedge clk);
    rstn <= 1;
    cfg_access(0, 8'hf4, 8'h00);
    cfg_access(0, 8'hf5, 8'h00);
    cfg_access(0, 8'h10, 8'h00);
    for (int i = 0; i < 48; i++) begin
      d = $urandom;
      d[4:3] = i[5:4];
      d[1:0] = i[3:2];
      k = $urandom;
      @(posedge clk);
      drive_sel <= k;
      rate_sel <= i[1:0];
      cfg_access(1, 8'hf4 + {7'h0, k[0]}, d);
      cfg_access(0, 8'hf4 + {7'h0, k[0]}, d & 8'h5b);
      repeat (2) @(posedge clk);
      note(1, pins(d, i[1:0]));
    end
    for (int i = 0; i < 64; i++) begin
      d = $urandom;
      d[4:0] = i[4:0];
      en = d[0] & d[1] & d[2] & !d[3];
      @(posedge clk);
      dor_wr <= 1;
      dor_wdata <= {4'h0, d[0], 3'h0};
      {powered_down, base_addr_valid, device_active} <= d[3:1];
      {dreq_in, core_dack, core_irq, at_mode, shared_rd} <= {d[7:4], !i[5]};
      @(posedge clk);
      dor_wr <= 0;
      @(posedge clk);
      note(2, {!en, !en, d[5], d[6], en & d[7], 3'h0});
      note(3, !(en & !i[5]) ? 8'h00 : d[4] ? 8'h80 : 8'hff);
    end
    cfg_access(1, 8'hf5, 8'h5b);
    host_reset_in <= 1;
    repeat (2) @(posedge clk);
    host_reset_in <= 0;
    repeat (8) @(posedge clk);
    cfg_access(0, 8'hf5, 8'h5b);
    host_reset_in <= 1;
    repeat (10) @(posedge clk);
    host_reset_in <= 0;
    repeat (10) @(posedge clk);
    cfg_access(0, 8'hf5, 8'h00);
    results;
  end
endmodule

// >>> rtl/fdrs_regs.vh
`ifndef FDRS_REGS_VH
`define FDRS_REGS_VH

// Configuration-space indices of the per-drive bytes
`define FDRS_IDX_DRIVE0 8'hf4
`define FDRS_IDX_DRIVE1 8'hf5
`define FDRS_CFG_RESET 8'h00

// Per-drive byte fields
`define FDRS_BIT_PRECOMP_DIS 6
`define FDRS_BIT_TABLE_HI 4
`define FDRS_BIT_TABLE_LO 3
`define FDRS_BIT_TYPE_LO 1
`define FDRS_BIT_TYPE_HI 0
`define FDRS_CFG_WMASK 8'h5b

// Rate tables
`define FDRS_TABLE_REGULAR 2'h0
`define FDRS_TABLE_THREE_MODE 2'h1
`define FDRS_TABLE_TAPE 2'h2

// Rate codes: 0 none, 1 1M, 2 500/250, 3 300/150, 4 250/125, 5 2M
`define FDRS_RATE_1M 3'h1
`define FDRS_RATE_500 3'h2
`define FDRS_RATE_300 3'h3
`define FDRS_RATE_250 3'h4
`define FDRS_RATE_2M 3'h5

// Digital output register
`define FDRS_DOR_DMA_GATE 3
`define FDRS_DOR_RESET 8'h00

// Host reset filter length in clock cycles
`define FDRS_FILTER_LEN 3'h4

// Shared-port read mask
`define FDRS_AT_MASK 8'h80
`define FDRS_FULL_MASK 8'hff

`endif

// >>> rtl/fdrs_reset_filter.v
`timescale 1ns/1ps
`include "fdrs_regs.vh"

// --------------------------------------------------------------
// Synchronise and debounce the host reset pin
// --------------------------------------------------------------
module fdrs_reset_filter (
  input wire clk,
  input wire rstn,
  input wire host_reset_in,
  output reg reset_filtered
);

  reg sync_a;
  reg sync_b;
  reg [2:0] count;

  always @(posedge clk) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      count <= 3'h0;
      reset_filtered <= 1'b0;
    end else begin
      sync_a <= host_reset_in;
      sync_b <= sync_a;
      // Level must hold FILTER_LEN cycles; glitches shorter never reset config
      if (sync_b == reset_filtered) begin
        count <= 3'h0;
      end else if (count == `FDRS_FILTER_LEN - 3'h1) begin
        count <= 3'h0;
        reset_filtered <= sync_b;
      end else begin
        count <= count + 3'h1;
      end
    end
  end

endmodule

// >>> rtl/fdrs_top.v
// Notes on behaviour
// RQ1 - Two per-drive bytes at indices f4, f5
// RQ2 - Bit six set disables write precompensation
// RQ3 - Bits four:three pick the rate table
// RQ4 - Rate selection maps to recommended data rate
// RQ5 - Density high for 11/00; rate equals selection
// RQ6 - Drive type routes codes onto density pins
// RQ7 - DMA gate clear floats IRQ, DACK, ignores DREQ
// RQ8 - Powered down controller floats IRQ and DACK
// RQ9 - Inactive or bad address floats IRQ, DACK
// RQ10 - AT mode drives only D7 on shared port
// RQ11 - PS/2 or Model 30 drives whole byte
// RQ12 - DMA mode defaults to non-burst
// RQ13 - Filtered host reset restores defaults, disables devices
// RQ14 - Selected drive's byte drives pins; reset zero
`timescale 1ns/1ps
`include "fdrs_regs.vh"

module fdrs_top (
  input wire clk,
  input wire rstn,
  input wire host_reset_in,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_index,
  input wire [7:0] cfg_wdata,
  output reg [7:0] cfg_rdata,
  input wire dor_wr,
  input wire [7:0] dor_wdata,
  input wire [1:0] drive_sel,
  input wire [1:0] rate_sel,
  input wire device_active,
  input wire base_addr_valid,
  input wire powered_down,
  input wire at_mode,
  input wire core_irq,
  input wire core_dack,
  input wire dreq_in,
  input wire shared_rd,
  output wire irq_out,
  output wire irq_oe_n,
  output wire dack_out,
  output wire dack_oe_n,
  output wire dreq_to_core,
  output wire [7:0] shared_data_mask,
  output reg density_pin_zero,
  output reg density_pin_one,
  output reg precomp_disable,
  output reg [2:0] selected_rate,
  output reg media_density_code,
  output reg dma_non_burst,
  output wire cfg_reset_active
);

  // --------------------------------------------------------------
  // Reset filtering
  // --------------------------------------------------------------
  // The pin is asynchronous; both sync stages live inside the filter
  wire reset_filtered;

  fdrs_reset_filter u_filter (
    .clk(clk),
    .rstn(rstn),
    .host_reset_in(host_reset_in),
    .reset_filtered(reset_filtered)
  );

  assign cfg_reset_active = reset_filtered;

  wire clear_all;
  assign clear_all = !rstn || reset_filtered; // [RQ13]

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  reg [7:0] drive0_rate_type_cfg;
  reg [7:0] drive1_rate_type_cfg;
  reg [7:0] dor;

  always @(posedge clk) begin
    if (clear_all) begin
      drive0_rate_type_cfg <= `FDRS_CFG_RESET; // [RQ14]
      drive1_rate_type_cfg <= `FDRS_CFG_RESET; // [RQ14]
      dor <= `FDRS_DOR_RESET;
      dma_non_burst <= 1'b1; // [RQ12]
    end else begin
      // Writes to any other index are dropped
      // Unused bits are fixed zero so reads match the layout
      if (cfg_wr && cfg_index == `FDRS_IDX_DRIVE0) begin
        drive0_rate_type_cfg <= cfg_wdata & `FDRS_CFG_WMASK; // [RQ1]
      end
      if (cfg_wr && cfg_index == `FDRS_IDX_DRIVE1) begin
        drive1_rate_type_cfg <= cfg_wdata & `FDRS_CFG_WMASK; // [RQ1]
      end
      if (dor_wr) begin
        dor <= dor_wdata;
      end
    end
  end

  always @(posedge clk) begin
    if (clear_all) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      // Read data stands until the next read strobe or a clear, which zeroes it
      case (cfg_index)
        `FDRS_IDX_DRIVE0: cfg_rdata <= drive0_rate_type_cfg; // [RQ1]
        `FDRS_IDX_DRIVE1: cfg_rdata <= drive1_rate_type_cfg; // [RQ1]
        default: cfg_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Rate and density mapping
  // --------------------------------------------------------------
  // Codes name the MFM rate; FM always runs at half of it
  function [2:0] rate_of;
    input [1:0] table_sel;
    input [1:0] sel;
    begin
      case (sel)
        2'h3: rate_of = `FDRS_RATE_1M;
        2'h0: rate_of = `FDRS_RATE_500;
        2'h2: rate_of = `FDRS_RATE_250;
        default: begin
          case (table_sel)
            `FDRS_TABLE_REGULAR: rate_of = `FDRS_RATE_300;
            `FDRS_TABLE_THREE_MODE: rate_of = `FDRS_RATE_500;
            `FDRS_TABLE_TAPE: rate_of = `FDRS_RATE_2M;
            default: rate_of = 3'h0;
          endcase
        end
      endcase
    end
  endfunction

  // Drive select bit 0 picks the byte; drives 2 and 3 alias 0 and 1
  wire [7:0] cur_cfg;
  assign cur_cfg = drive_sel[0] ? drive1_rate_type_cfg : drive0_rate_type_cfg; // [RQ14]

  wire [1:0] table_sel;
  wire [1:0] type_sel;
  wire density;
  wire media_density_code_inverted;
  wire rate_code_bit1;
  wire rate_code_bit0;
  wire rate_table_sel_hi;
  wire rate_table_sel_lo;
  wire drive_type_sel_hi;
  wire drive_type_sel_lo;

  assign rate_table_sel_hi = cur_cfg[`FDRS_BIT_TABLE_HI];
  assign rate_table_sel_lo = cur_cfg[`FDRS_BIT_TABLE_LO];
  // Table 11 is reserved; with selection 01 it reports no rate rather than guessing one
  assign table_sel = {rate_table_sel_hi, rate_table_sel_lo}; // [RQ3]
  assign drive_type_sel_hi = cur_cfg[`FDRS_BIT_TYPE_HI];
  assign drive_type_sel_lo = cur_cfg[`FDRS_BIT_TYPE_LO];
  // The two select bits sit swapped in the byte, so the code is byte bits 1:0
  assign type_sel = {drive_type_sel_lo, drive_type_sel_hi}; // [RQ6]
  assign density = (rate_sel == 2'h3) || (rate_sel == 2'h0); // [RQ5]
  assign media_density_code_inverted = !density;
  assign rate_code_bit1 = rate_sel[1]; // [RQ5]
  assign rate_code_bit0 = rate_sel[0]; // [RQ5]

  // Pins are registered so a drive never sees a decode glitch
  always @(posedge clk) begin
    if (clear_all) begin
      density_pin_zero <= 1'b0;
      density_pin_one <= 1'b0;
      precomp_disable <= 1'b0;
      selected_rate <= 3'h0;
      media_density_code <= 1'b0;
    end else begin
      precomp_disable <= cur_cfg[`FDRS_BIT_PRECOMP_DIS]; // [RQ2]
      selected_rate <= rate_of(table_sel, rate_sel); // [RQ4]
      media_density_code <= density;
      case (type_sel) // [RQ6]
        2'h0: begin
          density_pin_zero <= density;
          density_pin_one <= rate_code_bit0;
        end
        2'h1: begin
          density_pin_zero <= rate_code_bit1;
          density_pin_one <= rate_code_bit0;
        end
        2'h2: begin
          density_pin_zero <= media_density_code_inverted;
          density_pin_one <= rate_code_bit0;
        end
        default: begin
          density_pin_zero <= rate_code_bit0;
          density_pin_one <= rate_code_bit1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // IRQ / DACK gating and shared port
  // --------------------------------------------------------------
  wire dma_gate_bit;
  wire gate_open;
  assign dma_gate_bit = dor[`FDRS_DOR_DMA_GATE]; // [RQ7]
  // Host reset closes the gate at once, before the cleared gate bit takes effect
  assign gate_open = dma_gate_bit // [RQ7]
    && !powered_down // [RQ8]
    && device_active && base_addr_valid // [RQ9]
    && !clear_all; // [RQ13]

  // Enables are active low; a floated pin is left for the bus pull-up
  assign irq_out = core_irq;
  assign dack_out = core_dack;
  assign irq_oe_n = !gate_open; // [RQ7]
  assign dack_oe_n = !gate_open; // [RQ8]
  assign dreq_to_core = gate_open && dreq_in; // [RQ7]

  // Only the controller answers the shared port; disk-interface reads never decode
  assign shared_data_mask = (!shared_rd || !gate_open) ? 8'h00 :
    (at_mode ? `FDRS_AT_MASK : `FDRS_FULL_MASK); // [RQ10] [RQ11]

endmodule
